// ---- design/wdog_defines.svh ----
`ifndef WDOG_DEFINES_SVH
`define WDOG_DEFINES_SVH
// register byte offsets
`define WDOG_PRESCALER_OFS 12'h0400
`define WDOG_LOCAL_COUNT_OFS 12'h0410
`define WDOG_SYNC_COUNT_OFS 12'h0420
`define WDOG_STATUS_OFS 12'h0430
// reset values: 2498 and 1000 give 100 ms
`define WDOG_PRESCALER_RST 16'h09c2
`define WDOG_COUNT_RST 16'h03e8
`define WDOG_TIMEOUT_MS 100
// status register fields
`define WDOG_ST_SYNC_EXP_BIT 0
`define WDOG_ST_LOCAL_EXP_BIT 1
`define WDOG_ST_STATE_LSB 4
// timing: system clock and 25 MHz watchdog base
`define WDOG_CLK_PERIOD_NS 8
`define WDOG_BASE_PERIOD_NS 40
`define WDOG_BASE_DIV (`WDOG_BASE_PERIOD_NS / `WDOG_CLK_PERIOD_NS)
// a tick lasts prescaler plus this many base periods
`define WDOG_TICK_EXTRA 2
`endif

// ---- design/wdog_pkg.sv ----
package wdog_pkg;
   // five slave states
   typedef enum logic [2:0] {
      ST_POWER_ON,
      ST_MAILBOX_ONLY,
      ST_GUARDED_OUTPUT,
      ST_RUNNING,
      ST_FW_UPDATE
   } slave_state_t;
   // register access request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [15:0] wdata;
   } reg_req_t;
   // state change request
   typedef struct packed {
      logic valid;
      slave_state_t target;
   } state_req_t;
endpackage

// ---- design/fieldbus_slave_watchdog_fsm.sv ----
// Contract
// - both watchdogs default to 100 ms
// - one prescaler at 0x0400 for both
// - local count 0x0410, sync count 0x0420
// - tick is prescaler+2 periods of 40 ns
// - process-data access restarts sync watchdog
// - expiry drives outputs to preset value
// - sync expiry leaves slave state unchanged
// - sync expiry sticks until next access or until sync count is written to zero
// - local watchdog expires without local access
// - sync count zero disables that watchdog
// - five states incl. firmware update
// - power-on state: no mailbox, no data
// - check mailbox; mailbox-only refuses data
// - check data cfg, capture inputs, ack
// - guarded: traffic on, outputs held safe
// - running copies master outputs to pins
// - update state only via power-on, files
`timescale 1ns/100ps
`default_nettype none
`include "wdog_defines.svh"
module fieldbus_slave_watchdog_fsm #(
   parameter int OUT_W = 8,
   parameter logic [OUT_W-1:0] SAFE_VALUE = '0
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire wdog_pkg::reg_req_t i_reg,
   output logic [15:0] o_reg_rdata,
   output logic o_reg_ack,
   input wire logic i_pd_access_ok,
   input wire logic i_local_access,
   input wire wdog_pkg::state_req_t i_state_req,
   input wire logic i_mbx_cfg_ok,
   input wire logic i_pd_cfg_ok,
   output logic o_state_ack,
   output logic o_state_err,
   output logic o_input_capture,
   output wdog_pkg::slave_state_t o_state,
   output logic o_mbx_allowed,
   output logic o_file_mbx_only,
   output logic o_pd_allowed,
   output logic o_sync_wd_expired,
   output logic o_local_wd_expired,
   input wire logic [OUT_W-1:0] i_master_out,
   output logic [OUT_W-1:0] o_phys_out
);
   // watchdog index: 0 sync channel, 1 local interface
   localparam int WD_N = 2;
   localparam int DIV_W = 3;
   localparam logic [DIV_W-1:0] BASE_LAST = DIV_W'(`WDOG_BASE_DIV - 1);

   logic rst_meta_r; // first reset stage, read only by next
   logic rst_sync_r; // released reset, active low, 1 once released
   logic [15:0] prescaler_r; // shared tick length
   logic [15:0] count_r [WD_N]; // configured timeout counts
   logic [15:0] remain_r [WD_N]; // ticks left until expiry
   logic expired_r [WD_N]; // sticky expiry flags
   logic access [WD_N]; // restart events per watchdog
   logic [DIV_W-1:0] base_cnt_r; // 125 MHz to 25 MHz divider
   logic base_tick; // one 40 ns base period done
   logic [16:0] pre_cnt_r; // base periods in this tick
   logic wd_tick; // one watchdog tick done
   wdog_pkg::slave_state_t state_r; // slave state
   logic capture_r; // input copy before guarded ack
   logic ack_r; // state change acknowledged
   logic err_r; // state change refused
   logic any_expired;

   // reset release through two stages
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // register decode, shared by read and write
   function automatic logic hit(input logic [11:0] a,
                                input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction

   // configuration registers
   always_ff @(posedge i_mclk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         prescaler_r <= `WDOG_PRESCALER_RST;
         count_r[0] <= `WDOG_COUNT_RST;
         count_r[1] <= `WDOG_COUNT_RST;
      end else if (i_ce && i_reg.wr) begin
         if (hit(i_reg.addr, `WDOG_PRESCALER_OFS)) begin
            prescaler_r <= i_reg.wdata;
         end
         if (hit(i_reg.addr, `WDOG_SYNC_COUNT_OFS)) begin
            count_r[0] <= i_reg.wdata;
         end
         if (hit(i_reg.addr, `WDOG_LOCAL_COUNT_OFS)) begin
            count_r[1] <= i_reg.wdata;
         end
      end
   end

   // register reads, one cycle latency; unmapped reads zero
   always_ff @(posedge i_mclk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         o_reg_rdata <= 16'h0000;
         o_reg_ack <= 1'b0;
      end else if (i_ce) begin
         o_reg_ack <= i_reg.rd | i_reg.wr;
         o_reg_rdata <= 16'h0000;
         if (i_reg.rd) begin
            if (hit(i_reg.addr, `WDOG_PRESCALER_OFS)) begin
               o_reg_rdata <= prescaler_r;
            end else if (hit(i_reg.addr, `WDOG_LOCAL_COUNT_OFS)) begin
               o_reg_rdata <= count_r[1];
            end else if (hit(i_reg.addr, `WDOG_SYNC_COUNT_OFS)) begin
               o_reg_rdata <= count_r[0];
            end else if (hit(i_reg.addr, `WDOG_STATUS_OFS)) begin
               o_reg_rdata[`WDOG_ST_SYNC_EXP_BIT] <= expired_r[0];
               o_reg_rdata[`WDOG_ST_LOCAL_EXP_BIT] <= expired_r[1];
               o_reg_rdata[`WDOG_ST_STATE_LSB +: 3] <= state_r;
            end
         end
      end
   end

   // base period divider
   always_ff @(posedge i_mclk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         base_cnt_r <= '0;
      end else if (i_ce) begin
         if (base_tick) begin
            base_cnt_r <= '0;
         end else begin
            base_cnt_r <= base_cnt_r + DIV_W'(1);
         end
      end
   end
   assign base_tick = (base_cnt_r == BASE_LAST);

   always_ff @(posedge i_mclk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         pre_cnt_r <= '0;
      end else if (i_ce && base_tick) begin
         if (wd_tick) begin
            pre_cnt_r <= '0;
         end else begin
            pre_cnt_r <= pre_cnt_r + 17'h0_0001;
         end
      end
   end
   // at or past the end: a smaller prescaler written mid-tick
   // ends the tick at once instead of waiting for a wrap
   assign wd_tick = base_tick && (pre_cnt_r >=
      ({1'b0, prescaler_r} + 17'(`WDOG_TICK_EXTRA - 1)));

   assign access[0] = i_pd_access_ok;
   assign access[1] = i_local_access;

   // both watchdog counters
   genvar g;
   generate
      for (g = 0; g < WD_N; g++) begin : g_wd
         always_ff @(posedge i_mclk or negedge rst_sync_r) begin
            if (!rst_sync_r) begin
               remain_r[g] <= `WDOG_COUNT_RST;
               expired_r[g] <= 1'b0;
            end else if (i_ce) begin
               if (access[g]) begin
                  remain_r[g] <= count_r[g];
                  expired_r[g] <= 1'b0;
               end else if (count_r[g] == 16'h0000) begin
                  remain_r[g] <= 16'h0000;
                  expired_r[g] <= 1'b0;
               end else if (wd_tick && !expired_r[g]) begin
                  if (remain_r[g] <= 16'h0001) begin
                     // timeout reached, flag sticks
                     remain_r[g] <= 16'h0000;
                     expired_r[g] <= 1'b1;
                  end else begin
                     remain_r[g] <= remain_r[g] - 16'h0001;
                  end
               end
            end
         end
      end
   endgenerate

   assign o_sync_wd_expired = expired_r[0];
   assign o_local_wd_expired = expired_r[1];
   assign any_expired = expired_r[0] | expired_r[1];

   // slave state sequencing; expiry never enters here
   // state independent of watchdogs
   always_ff @(posedge i_mclk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         state_r <= wdog_pkg::ST_POWER_ON;
         capture_r <= 1'b0;
         ack_r <= 1'b0;
         err_r <= 1'b0;
      end else if (i_ce) begin
         ack_r <= 1'b0;
         err_r <= 1'b0;
         capture_r <= 1'b0;
         if (capture_r) begin
            state_r <= wdog_pkg::ST_GUARDED_OUTPUT;
            ack_r <= 1'b1;
         end else if (i_state_req.valid) begin
            case (state_r)
               wdog_pkg::ST_POWER_ON: begin
                  if (i_state_req.target ==
                      wdog_pkg::ST_MAILBOX_ONLY && i_mbx_cfg_ok) begin
                     state_r <= wdog_pkg::ST_MAILBOX_ONLY;
                     ack_r <= 1'b1;
                  end else if (i_state_req.target ==
                               wdog_pkg::ST_FW_UPDATE) begin
                     state_r <= wdog_pkg::ST_FW_UPDATE;
                     ack_r <= 1'b1;
                  end else if (i_state_req.target ==
                               wdog_pkg::ST_POWER_ON) begin
                     ack_r <= 1'b1;
                  end else begin
                     err_r <= 1'b1;
                  end
               end
               wdog_pkg::ST_MAILBOX_ONLY: begin
                  if (i_state_req.target ==
                      wdog_pkg::ST_GUARDED_OUTPUT && i_pd_cfg_ok) begin
                     capture_r <= 1'b1;
                  end else if (i_state_req.target ==
                               wdog_pkg::ST_POWER_ON ||
                               i_state_req.target ==
                               wdog_pkg::ST_MAILBOX_ONLY) begin
                     state_r <= i_state_req.target;
                     ack_r <= 1'b1;
                  end else begin
                     err_r <= 1'b1;
                  end
               end
               wdog_pkg::ST_GUARDED_OUTPUT,
               wdog_pkg::ST_RUNNING: begin
                  // downward moves and running allowed
                  if (i_state_req.target != wdog_pkg::ST_FW_UPDATE) begin
                     state_r <= i_state_req.target;
                     ack_r <= 1'b1;
                  end else begin
                     err_r <= 1'b1;
                  end
               end
               wdog_pkg::ST_FW_UPDATE: begin
                  // leave update only back to power-on
                  if (i_state_req.target == wdog_pkg::ST_POWER_ON ||
                      i_state_req.target == wdog_pkg::ST_FW_UPDATE) begin
                     state_r <= i_state_req.target;
                     ack_r <= 1'b1;
                  end else begin
                     err_r <= 1'b1;
                  end
               end
               default: begin
                  state_r <= wdog_pkg::ST_POWER_ON;
                  err_r <= 1'b1;
               end
            endcase
         end
      end
   end

   assign o_state = state_r;
   assign o_state_ack = ack_r;
   assign o_state_err = err_r;
   assign o_input_capture = capture_r;

   // traffic permissions per state
   // power-on refuses all traffic
   assign o_mbx_allowed = (state_r != wdog_pkg::ST_POWER_ON);
   // update state takes file mailbox only
   assign o_file_mbx_only = (state_r == wdog_pkg::ST_FW_UPDATE);
   assign o_pd_allowed = (state_r == wdog_pkg::ST_GUARDED_OUTPUT) ||
                         (state_r == wdog_pkg::ST_RUNNING);

   // physical outputs; safe unless running and fed
   always_ff @(posedge i_mclk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         o_phys_out <= SAFE_VALUE;
      end else if (i_ce) begin
         if (any_expired) begin
            o_phys_out <= SAFE_VALUE;
         end else if (state_r == wdog_pkg::ST_RUNNING) begin
            o_phys_out <= i_master_out;
         end else begin
            o_phys_out <= SAFE_VALUE;
         end
      end
   end
endmodule // fieldbus_slave_watchdog_fsm
`default_nettype wire

// ---- tb/wdog_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module wdog_checker #(
   parameter int OUT_W = 8,
   parameter logic [OUT_W-1:0] SAFE_VALUE = '0
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire wdog_pkg::reg_req_t i_reg,
   input wire logic [15:0] o_reg_rdata,
   input wire logic o_reg_ack,
   input wire logic i_pd_access_ok,
   input wire wdog_pkg::state_req_t i_state_req,
   input wire logic i_mbx_cfg_ok,
   input wire logic i_pd_cfg_ok,
   input wire logic o_state_ack,
   input wire logic o_state_err,
   input wire logic o_input_capture,
   input wire wdog_pkg::slave_state_t o_state,
   input wire logic o_mbx_allowed,
   input wire logic o_file_mbx_only,
   input wire logic o_pd_allowed,
   input wire logic o_sync_wd_expired,
   input wire logic o_local_wd_expired,
   input wire logic [OUT_W-1:0] i_master_out,
   input wire logic [OUT_W-1:0] o_phys_out
);
   // edges since release; design answers from the third on
   logic [1:0] up_r;
   logic rdy;
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) up_r <= 2'h0;
      else if (!rdy) up_r <= up_r + 2'h1;
   end
   assign rdy = (up_r == 2'h3);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   // mailbox-only to guarded: capture, then ack
   sequence s_to_guard;
      rdy && i_ce && i_state_req.valid && !o_input_capture && i_pd_cfg_ok &&
      o_state == wdog_pkg::ST_MAILBOX_ONLY &&
      i_state_req.target == wdog_pkg::ST_GUARDED_OUTPUT;
   endsequence
   sequence s_cap_ack;
      o_input_capture ##1 (o_state_ack &&
         o_state == wdog_pkg::ST_GUARDED_OUTPUT);
   endsequence
   property p_guard; s_to_guard |=> s_cap_ack; endproperty
   a_guard: assert property (p_guard)
      else $error("no capture before guarded ack");
   property p_ack;
      rdy && $past(rdy) |-> o_reg_ack == $past(i_ce && (i_reg.wr || i_reg.rd));
   endproperty
   a_ack: assert property (p_ack)
      else $error("register ack timing wrong");
   property p_unmapped;
      rdy && i_ce && i_reg.rd && !(i_reg.addr inside {12'h0400, 12'h0410,
         12'h0420, 12'h0430}) |=> o_reg_rdata == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_refuse;
      rdy && i_ce && i_state_req.valid && !i_mbx_cfg_ok &&
      o_state == wdog_pkg::ST_POWER_ON &&
      i_state_req.target == wdog_pkg::ST_MAILBOX_ONLY
      |=> o_state_err && o_state == wdog_pkg::ST_POWER_ON;
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("bad mailbox config accepted");
   property p_sticky;
      o_sync_wd_expired && !i_pd_access_ok && !i_reg.wr && !$past(i_reg.wr)
      |=> o_sync_wd_expired;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("sync expiry dropped without access");
   property p_clear; rdy && i_ce && i_pd_access_ok |=> !o_sync_wd_expired;
   endproperty
   a_clear: assert property (p_clear)
      else $error("access did not clear sync expiry");
   property p_hold;
      $rose(o_sync_wd_expired) && !o_state_ack |-> $stable(o_state);
   endproperty
   a_hold: assert property (p_hold)
      else $error("sync expiry changed state");
   // outputs follow master only when running and no expiry
   property p_out;
      rdy && $past(rdy) && $stable(o_state) && $stable(o_sync_wd_expired) &&
      $stable(o_local_wd_expired) |-> o_phys_out ==
      ((o_state == wdog_pkg::ST_RUNNING && !o_sync_wd_expired &&
      !o_local_wd_expired) ? $past(i_master_out) : SAFE_VALUE);
   endproperty
   a_out: assert property (p_out)
      else $error("physical outputs wrong");
   property p_decode;
      o_state != wdog_pkg::ST_FW_UPDATE |-> !o_file_mbx_only &&
      o_mbx_allowed == (o_state != wdog_pkg::ST_POWER_ON) &&
      o_pd_allowed == (o_state inside {wdog_pkg::ST_GUARDED_OUTPUT,
      wdog_pkg::ST_RUNNING});
   endproperty
   a_decode: assert property (p_decode)
      else $error("traffic permission decode wrong");
   property p_fw;
      $changed(o_state) && o_state == wdog_pkg::ST_FW_UPDATE |->
      $past(o_state) == wdog_pkg::ST_POWER_ON && o_file_mbx_only &&
      !o_pd_allowed;
   endproperty
   a_fw: assert property (p_fw)
      else $error("update state entered wrongly");
endmodule // wdog_checker
`default_nettype wire

// ---- tb/fieldbus_far_side.sv ----
`timescale 1ns/100ps
`default_nettype none
module fieldbus_far_side #(
   parameter int OUT_W = 8
) (
   input wire logic i_mclk,
   input wire logic i_pd_en,
   input wire logic i_local_en,
   output logic o_pd_access_ok,
   output logic o_local_access,
   output logic [OUT_W-1:0] o_master_out
);
   logic [1:0] phase_r = 2'h0; // spaces the two access kinds apart
   logic pd_en_r = 1'b0; // enables as seen at the edge, no race
   logic local_en_r = 1'b0;
   // valid output data from the start
   initial o_master_out = OUT_W'(8'h5a);
   initial o_pd_access_ok = 1'b0;
   initial o_local_access = 1'b0;
   always @(posedge i_mclk) begin
      pd_en_r = i_pd_en;
      local_en_r = i_local_en;
      #1;
      phase_r = phase_r + 2'h1;
      o_pd_access_ok = pd_en_r && phase_r == 2'h0;
      o_local_access = local_en_r && phase_r == 2'h2;
   end
endmodule // fieldbus_far_side
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic i_mclk = 1'b0;
   logic i_rst_n = 1'b0;
   wdog_pkg::reg_req_t i_reg = '0;
   wdog_pkg::state_req_t i_state_req = '0;
   logic i_mbx_cfg_ok = 1'b0;
   logic i_pd_cfg_ok = 1'b0;
   logic pd_en = 1'b0;
   logic local_en = 1'b0;
   logic pd_acc, loc_acc, cap_seen, ack, st_ack, st_err, cap;
   logic mbx, fonly, pd, sexp, lexp;
   logic [7:0] mout, pout;
   logic [15:0] rdata;
   wdog_pkg::slave_state_t state;
   int errors = 0;
   int comparisons = 0;
   int n;
   always #4 i_mclk = ~i_mclk;
   fieldbus_slave_watchdog_fsm uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
      .i_ce(1'b1), .i_reg(i_reg), .o_reg_rdata(rdata), .o_reg_ack(ack),
      .i_pd_access_ok(pd_acc), .i_local_access(loc_acc),
      .i_state_req(i_state_req), .i_mbx_cfg_ok(i_mbx_cfg_ok),
      .i_pd_cfg_ok(i_pd_cfg_ok), .o_state_ack(st_ack), .o_state_err(st_err),
      .o_input_capture(cap), .o_state(state), .o_mbx_allowed(mbx),
      .o_file_mbx_only(fonly), .o_pd_allowed(pd), .o_sync_wd_expired(sexp),
      .o_local_wd_expired(lexp), .i_master_out(mout), .o_phys_out(pout));
   fieldbus_far_side far (.i_mclk(i_mclk), .i_pd_en(pd_en),
      .i_local_en(local_en), .o_pd_access_ok(pd_acc),
      .o_local_access(loc_acc), .o_master_out(mout));
   // one compare for every result, widened to 16 bits
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge i_mclk);
      #1;
   endtask
   task automatic reg_acc(input logic w, input logic [11:0] a,
                          input logic [15:0] d);
      i_reg = '{wr: w, rd: !w, addr: a, wdata: d};
      tick(1);
      i_reg = '0;
      chk(ack, 16'h0001);
      if (!w) chk(rdata, d);
      tick(1);
   endtask
   // ack or refusal, capture pulse may come first
   task automatic req(input wdog_pkg::slave_state_t t, input logic ok);
      i_state_req = '{valid: 1'b1, target: t};
      tick(1);
      i_state_req = '0;
      cap_seen = cap;
      if (!st_ack && !st_err) tick(1);
      chk(st_ack, ok);
      chk(st_err, !ok);
      tick(1);
   endtask
   task automatic end_of_test;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // measure cycles until an expiry flag rises
   task automatic wait_exp(input logic sync);
      for (n = 0; n < 60 && !(sync ? sexp : lexp); n++) tick(1);
   endtask
   initial begin
      repeat (8) @(posedge i_mclk);
      #1;
      i_rst_n = 1'b1;
      tick(3);
      reg_acc(1'b0, 12'h0400, 16'h09c2);
      reg_acc(1'b0, 12'h0410, 16'h03e8);
      reg_acc(1'b0, 12'h0420, 16'h03e8);
      reg_acc(1'b0, 12'h0404, 16'h0000);
      chk({mbx, pd}, 16'h0000);
      req(wdog_pkg::ST_RUNNING, 1'b0);
      req(wdog_pkg::ST_MAILBOX_ONLY, 1'b0);
      req(wdog_pkg::ST_FW_UPDATE, 1'b1);
      chk({fonly, pd}, 16'h0002);
      req(wdog_pkg::ST_MAILBOX_ONLY, 1'b0);
      req(wdog_pkg::ST_POWER_ON, 1'b1);
      i_mbx_cfg_ok = 1'b1; // mailbox channels set
      req(wdog_pkg::ST_MAILBOX_ONLY, 1'b1);
      chk({mbx, pd}, 16'h0002);
      req(wdog_pkg::ST_FW_UPDATE, 1'b0);
      req(wdog_pkg::ST_GUARDED_OUTPUT, 1'b0);
      // short timeouts: tick of 10 clocks, three ticks
      reg_acc(1'b1, 12'h0400, 16'h0000);
      reg_acc(1'b1, 12'h0410, 16'h0003);
      reg_acc(1'b1, 12'h0420, 16'h0003);
      reg_acc(1'b0, 12'h0420, 16'h0003);
      i_pd_cfg_ok = 1'b1; // data channels set
      local_en = 1'b1;
      pd_en = 1'b1;
      req(wdog_pkg::ST_GUARDED_OUTPUT, 1'b1);
      chk(cap_seen, 16'h0001);
      chk({mbx, pd, pout}, 16'h0300);
      req(wdog_pkg::ST_RUNNING, 1'b1);
      tick(2);
      chk(pout, mout);
      pd_en = 1'b0;
      wait_exp(1'b1);
      chk(n >= 15 && n <= 31, 16'h0001);
      tick(1);
      chk({state, pout}, 16'h0300);
      tick(40);
      reg_acc(1'b0, 12'h0430, 16'h0031);
      pd_en = 1'b1;
      tick(6);
      chk({sexp, pout}, mout);
      local_en = 1'b0;
      wait_exp(1'b0);
      chk(n >= 15 && n <= 31, 16'h0001);
      tick(1);
      reg_acc(1'b0, 12'h0430, 16'h0032);
      chk({lexp, pout}, 16'h0100);
      local_en = 1'b1;
      reg_acc(1'b1, 12'h0420, 16'h0000);
      tick(8);
      pd_en = 1'b0;
      tick(80);
      chk({sexp, lexp, pout}, mout);
      end_of_test();
   end
   initial begin
      #50000;
      errors++;
      end_of_test();
   end
endmodule // tb_top
bind fieldbus_slave_watchdog_fsm wdog_checker #(.OUT_W(OUT_W),
   .SAFE_VALUE(SAFE_VALUE)) chk_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
   .i_ce(i_ce), .i_reg(i_reg), .o_reg_rdata(o_reg_rdata),
   .o_reg_ack(o_reg_ack), .i_pd_access_ok(i_pd_access_ok),
   .i_state_req(i_state_req), .i_mbx_cfg_ok(i_mbx_cfg_ok),
   .i_pd_cfg_ok(i_pd_cfg_ok), .o_state_ack(o_state_ack),
   .o_state_err(o_state_err), .o_input_capture(o_input_capture),
   .o_state(o_state), .o_mbx_allowed(o_mbx_allowed),
   .o_file_mbx_only(o_file_mbx_only), .o_pd_allowed(o_pd_allowed),
   .o_sync_wd_expired(o_sync_wd_expired),
   .o_local_wd_expired(o_local_wd_expired), .i_master_out(i_master_out),
   .o_phys_out(o_phys_out));
`default_nettype wire
